//--- pkg/bls_pkg.sv
// Shared constants and types of the byte load/store execution unit
package bls_pkg;
  // Data path and register file
  localparam int DW = 24;
  localparam int BW = 8;
  localparam int NREG = 8;
  localparam int RIDX_W = 3;
  localparam logic [DW-1:0] RST_REG = 24'h000000;
  localparam logic [DW-1:0] STEP_ONE = 24'h000001;
  // Operation codes
  localparam int OP_W = 3;
  localparam logic [OP_W-1:0] OP_LD_SB = 3'h0;
  localparam logic [OP_W-1:0] OP_LOAD_UNSIGNED_BYTE = 3'h1;
  localparam logic [OP_W-1:0] OP_ST_B = 3'h2;
  localparam logic [OP_W-1:0] OP_MV_SB = 3'h3;
  localparam logic [OP_W-1:0] OP_MV_UB = 3'h4;
  // Addressing forms
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MD_IND = 3'h0;
  localparam logic [MODE_W-1:0] MD_PINC = 3'h1;
  localparam logic [MODE_W-1:0] MD_PDEC = 3'h2;
  localparam logic [MODE_W-1:0] MD_PRED = 3'h3;
  localparam logic [MODE_W-1:0] MD_SPD = 3'h4;
  localparam logic [MODE_W-1:0] MD_ABS = 3'h5;
  // Immediate width forms
  localparam int EXT_W = 2;
  localparam logic [EXT_W-1:0] EX_BASIC = 2'h0;
  localparam logic [EXT_W-1:0] EX_20 = 2'h1;
  localparam logic [EXT_W-1:0] EX_24 = 2'h2;
  localparam int IMM_BASIC_W = 7;
  localparam int IMM_20_W = 20;
  // Access size codes on the memory port
  localparam int SZ_W = 2;
  localparam logic [SZ_W-1:0] SZ_BYTE = 2'h0;
  localparam logic [SZ_W-1:0] SZ_WORD = 2'h1;
  localparam logic [SZ_W-1:0] SZ_LONG = 2'h2;
  // Flags: N=0 Z=1 V=2 C=3 IE=4 IL=7..5
  localparam int FLW = 8;
  localparam logic [FLW-1:0] RST_FLAGS = 8'h00;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FETCH = 3'h2,
    ST_MEM = 3'h4
  } bls_state_type;
endpackage : bls_pkg

//--- pkg/bls_rf_if.sv
// Register file access bundle between sequencer and register file
`timescale 1ns/100ps
`default_nettype none
interface bls_rf_if;
  import bls_pkg::*;
  logic [RIDX_W-1:0] ra_a;
  logic [RIDX_W-1:0] ra_b;
  logic [RIDX_W-1:0] ra_c;
  logic [DW-1:0] rd_a;
  logic [DW-1:0] rd_b;
  logic [DW-1:0] rd_c;
  logic we_a;
  logic [RIDX_W-1:0] wa_a;
  logic [DW-1:0] wd_a;
  logic we_b;
  logic [RIDX_W-1:0] wa_b;
  logic [DW-1:0] wd_b;
  modport core (output ra_a, ra_b, ra_c, we_a, wa_a, wd_a, we_b, wa_b, wd_b,
                input rd_a, rd_b, rd_c);
  modport rf (input ra_a, ra_b, ra_c, we_a, wa_a, wd_a, we_b, wa_b, wd_b,
              output rd_a, rd_b, rd_c);
endinterface : bls_rf_if
`default_nettype wire

//--- sim/bls_mem_model.sv
// Behavioural byte memory serving the execution unit's access port
`timescale 1ns/100ps
`default_nettype none
module bls_mem_model (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic req, // Access request
  input wire logic we, // Write access
  input wire logic [23:0] addr, // Byte address
  input wire logic [7:0] wdata, // Store byte
  input wire logic [1:0] size, // Access size code
  input wire logic [7:0] dly, // Wait cycles before answer
  output logic ack, // Access finished
  output logic [7:0] rdata // Load byte
);
  // ----------------------------------------------------------------
  // Storage and access log
  // ----------------------------------------------------------------
  logic [7:0] mem [logic [23:0]];
  int cnt;
  int n_acc;
  logic [23:0] last_addr;
  logic last_we;
  logic [7:0] last_wdata;
  logic [1:0] last_size;
  // ----------------------------------------------------------------
  // Answer after dly cycles; read data toggles when not valid
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rdata <= 8'h00;
      cnt <= 0;
      n_acc <= 0;
    end else if (req && !ack) begin
      if (cnt >= int'(dly)) begin
        ack <= 1'b1;
        cnt <= 0;
        n_acc <= n_acc + 1;
        last_addr <= addr;
        last_we <= we;
        last_wdata <= wdata;
        last_size <= size;
        if (we) begin
          mem[addr] = wdata;
        end
        rdata <= mem.exists(addr) ? mem[addr] : (addr[7:0] ^ 8'hA5);
      end else begin
        cnt <= cnt + 1;
        rdata <= ~rdata;
      end
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
    end
  end
endmodule : bls_mem_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench of the byte load/store execution unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import bls_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ins_valid = 1'b0, ins_ready, ins_delay = 1'b0, ins_done, ins_illegal;
  logic [OP_W-1:0] ins_op = OP_LD_SB;
  logic [MODE_W-1:0] ins_mode = MD_IND;
  logic [EXT_W-1:0] ins_ext = EX_BASIC;
  logic [RIDX_W-1:0] ins_rd = 3'h0, ins_rs = 3'h0, ins_rb = 3'h0, ld_sel = 3'h0, dbg_sel = 3'h0;
  logic [DW-1:0] ins_imm = 24'h000000, sp = 24'h000000, ld_data = 24'h000000, dbg_data, mem_addr;
  logic mem_req, mem_we, mem_ack, rf_ld = 1'b0, flags_ld = 1'b0;
  logic [BW-1:0] mem_wdata, mem_rdata;
  logic [SZ_W-1:0] mem_size;
  logic [FLW-1:0] flags_in = 8'h00, flags_out;
  logic [7:0] dly = 8'h00;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic ill;
  logic [DW-1:0] v;
  int n0;
  always #4 clk = ~clk;
  bls_exec i_dut (.CORE_CLK(clk), .SYS_RST(rst), .INS_VALID(ins_valid), .INS_READY(ins_ready),
    .INS_OP(ins_op), .INS_MODE(ins_mode), .INS_EXT(ins_ext), .INS_DELAY(ins_delay),
    .INS_RD(ins_rd), .INS_RS(ins_rs), .INS_RB(ins_rb), .INS_IMM(ins_imm), .SP_VALUE(sp),
    .INS_DONE(ins_done), .INS_ILLEGAL(ins_illegal), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_SIZE(mem_size), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .RF_LD(rf_ld), .RF_LD_SEL(ld_sel), .RF_LD_DATA(ld_data),
    .DBG_SEL(dbg_sel), .DBG_DATA(dbg_data), .FLAGS_LD(flags_ld), .FLAGS_IN(flags_in),
    .FLAGS_OUT(flags_out));
  bls_mem_model i_mem (.clk(clk), .rst(rst), .req(mem_req), .we(mem_we), .addr(mem_addr),
    .wdata(mem_wdata), .size(mem_size), .dly(dly), .ack(mem_ack), .rdata(mem_rdata));
  // ----------------------------------------------------------------
  // Shared bus tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task automatic preload(input logic [2:0] idx, input logic [23:0] d);
    @(negedge clk);
    rf_ld = 1'b1;
    ld_sel = idx;
    ld_data = d;
    @(negedge clk);
    rf_ld = 1'b0;
  endtask : preload
  task automatic rd_reg(input logic [2:0] idx, output logic [23:0] d);
    @(negedge clk);
    dbg_sel = idx;
    repeat (2) @(negedge clk);
    d = dbg_data;
  endtask : rd_reg
  task automatic issue(input logic [2:0] op, md, input logic [1:0] ex, input logic dl,
                       input logic [2:0] rd, rs, rb, input logic [23:0] imm);
    int n;
    @(negedge clk);
    ins_op = op;
    ins_mode = md;
    ins_ext = ex;
    ins_delay = dl;
    ins_rd = rd;
    ins_rs = rs;
    ins_rb = rb;
    ins_imm = imm;
    ins_valid = 1'b1;
    n = 0;
    while (ins_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    ins_valid = 1'b0;
    `CHK("ready", dl && ex != EX_BASIC, ins_ready)
    n = 0;
    while (ins_done !== 1'b1 && ins_illegal !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    ill = ins_illegal;
    `CHK("finish", 1'b1, ins_done | ins_illegal)
  endtask : issue
  task automatic chk_acc(input logic [23:0] a, input logic w);
    `CHK("illegal", 1'b0, ill)
    `CHK("addr", a, i_mem.last_addr)
    `CHK("we", w, i_mem.last_we)
    `CHK("size", SZ_BYTE, i_mem.last_size)
  endtask : chk_acc
  task automatic chk_reg(input string nm, input logic [2:0] idx, input logic [23:0] ex);
    rd_reg(idx, v);
    `CHK(nm, ex, v)
  endtask : chk_reg
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      preload(3'(i), 24'h030201 * 24'(i + 1));
      chk_reg("reg", 3'(i), 24'h030201 * 24'(i + 1));
    end
  endtask : t_regs
  task automatic t_post();
    preload(3, 24'h00FFFF);
    preload(5, 24'hFFFFFF);
    i_mem.mem[24'h00FFFF] = 8'h80;
    issue(OP_LD_SB, MD_PINC, EX_BASIC, 1'b0, 5, 0, 3, 24'h0);
    chk_acc(24'h00FFFF, 1'b0);
    chk_reg("sdest", 5, 24'h00FF80);
    chk_reg("pinc", 3, 24'h010000);
    dly = 8'h05;
    preload(2, 24'h000000);
    i_mem.mem[24'h000000] = 8'h80;
    issue(OP_LOAD_UNSIGNED_BYTE, MD_PDEC, EX_BASIC, 1'b0, 6, 0, 2, 24'h0);
    chk_acc(24'h000000, 1'b0);
    chk_reg("udest", 6, 24'h000080);
    chk_reg("pdec", 2, 24'hFFFFFF);
    dly = 8'h00;
  endtask : t_post
  task automatic t_store();
    preload(1, 24'h000010);
    preload(4, 24'hABCD5A);
    issue(OP_ST_B, MD_PRED, EX_BASIC, 1'b0, 0, 4, 1, 24'h0);
    chk_acc(24'h00000F, 1'b1);
    `CHK("wdata", 8'h5A, i_mem.last_wdata)
    chk_reg("pred", 1, 24'h00000F);
    issue(OP_LD_SB, MD_IND, EX_BASIC, 1'b0, 7, 0, 1, 24'h0);
    chk_acc(24'h00000F, 1'b0);
    chk_reg("back", 7, 24'h00005A);
    chk_reg("ind", 1, 24'h00000F);
  endtask : t_store
  task automatic t_sp();
    sp = 24'h001000;
    i_mem.mem[24'h00107F] = 8'hC3;
    issue(OP_LD_SB, MD_SPD, EX_BASIC, 1'b0, 0, 0, 0, 24'hFFFFFF);
    chk_acc(24'h00107F, 1'b0);
    chk_reg("spsgn", 0, 24'h00FFC3);
    issue(OP_LOAD_UNSIGNED_BYTE, MD_SPD, EX_BASIC, 1'b0, 0, 0, 0, 24'hFFFFFF);
    chk_reg("spuns", 0, 24'h0000C3);
  endtask : t_sp
  task automatic t_ext();
    i_mem.mem[24'h0FFFFF] = 8'h9E;
    issue(OP_LOAD_UNSIGNED_BYTE, MD_ABS, EX_20, 1'b0, 0, 0, 0, 24'hFFFFFF);
    chk_acc(24'h0FFFFF, 1'b0);
    chk_reg("e20", 0, 24'h00009E);
    sp = 24'h000100;
    issue(OP_LOAD_UNSIGNED_BYTE, MD_SPD, EX_24, 1'b0, 0, 0, 0, 24'hFFFF00);
    chk_acc(24'h000000, 1'b0);
    issue(OP_ST_B, MD_ABS, EX_20, 1'b0, 0, 4, 0, 24'h123456);
    chk_acc(24'h023456, 1'b1);
    `CHK("e20st", 8'h5A, i_mem.last_wdata)
  endtask : t_ext
  task automatic t_delay();
    issue(OP_LOAD_UNSIGNED_BYTE, MD_IND, EX_BASIC, 1'b1, 6, 0, 1, 24'h0);
    `CHK("dslot", 1'b0, ill)
    preload(0, 24'h777777);
    n0 = i_mem.n_acc;
    issue(OP_LOAD_UNSIGNED_BYTE, MD_ABS, EX_24, 1'b1, 0, 0, 0, 24'h000010);
    `CHK("dext", 1'b1, ill)
    `CHK("noacc", n0, i_mem.n_acc)
    chk_reg("keep", 0, 24'h777777);
  endtask : t_delay
  task automatic t_move();
    preload(4, 24'h1234F0);
    issue(OP_MV_SB, MD_IND, EX_BASIC, 1'b0, 7, 4, 0, 24'h0);
    chk_reg("mvs", 7, 24'h00FFF0);
    issue(OP_MV_UB, MD_IND, EX_BASIC, 1'b0, 6, 4, 0, 24'h0);
    chk_reg("mvu", 6, 24'h0000F0);
  endtask : t_move
  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    flags_ld = 1'b1;
    flags_in = 8'hB5;
    @(negedge clk);
    flags_ld = 1'b0;
    t_regs();
    t_post();
    t_store();
    t_sp();
    t_ext();
    t_delay();
    t_move();
    `CHK("flags", 8'hB5, flags_out)
    conclude();
  end
endmodule : tb_top
`default_nettype wire

//--- verilog/bls_exec.sv
// Byte load/store execution unit: decode, address, access, write-back
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// How it works
// - Eight 24-bit general registers, any one usable as destination, source or base.
// - Signed byte load: byte in 7..0, bit 7 copied to 15..8, 23..16 cleared.
// - Post-increment: access at old base, then base plus one over 24 bits.
// - Post-decrement: access at old base, then base minus one over 24 bits.
// - Pre-decrement: base minus one first, access at the decremented address.
// - Signed load from stack pointer plus 7-bit displacement, sign-extended into 15..8.
// - Unsigned byte load: byte in 7..0, bits 15..8 and 23..16 cleared.
// - Unsigned load from stack pointer plus displacement zeroes upper sixteen bits.
// - Byte store writes source bits 7..0 only, same base adjustment as loads.
// - Extended forms take 20- or 24-bit immediates, absolute or stack relative.
// - Unsigned immediates are zero-extended over their own bit count.
// - Extended forms in a delay slot are refused; basic forms are accepted.
// - Access size codes: byte, 16-bit word, 32-bit long; byte used here.
// ----------------------------------------------------------------
module bls_exec (
  input wire logic CORE_CLK, // Core clock
  input wire logic SYS_RST, // Async reset, high
  input wire logic INS_VALID, // Instruction offered
  output logic INS_READY, // Unit idle
  input wire logic [bls_pkg::OP_W-1:0] INS_OP, // Operation
  input wire logic [bls_pkg::MODE_W-1:0] INS_MODE, // Addressing form
  input wire logic [bls_pkg::EXT_W-1:0] INS_EXT, // Immediate width form
  input wire logic INS_DELAY, // Instruction in delay slot
  input wire logic [bls_pkg::RIDX_W-1:0] INS_RD, // Destination index
  input wire logic [bls_pkg::RIDX_W-1:0] INS_RS, // Source index
  input wire logic [bls_pkg::RIDX_W-1:0] INS_RB, // Base index
  input wire logic [bls_pkg::DW-1:0] INS_IMM, // Raw immediate
  input wire logic [bls_pkg::DW-1:0] SP_VALUE, // Stack pointer
  output logic INS_DONE, // Completion pulse
  output logic INS_ILLEGAL, // Refusal pulse
  output logic MEM_REQ, // Access request
  output logic MEM_WE, // Write access
  output logic [bls_pkg::DW-1:0] MEM_ADDR, // Byte address
  output logic [bls_pkg::BW-1:0] MEM_WDATA, // Store byte
  output logic [bls_pkg::SZ_W-1:0] MEM_SIZE, // Access size code
  input wire logic MEM_ACK, // Access finished
  input wire logic [bls_pkg::BW-1:0] MEM_RDATA, // Load byte
  input wire logic RF_LD, // Preload a register
  input wire logic [bls_pkg::RIDX_W-1:0] RF_LD_SEL, // Preload index
  input wire logic [bls_pkg::DW-1:0] RF_LD_DATA, // Preload value
  input wire logic [bls_pkg::RIDX_W-1:0] DBG_SEL, // Observe index
  output logic [bls_pkg::DW-1:0] DBG_DATA, // Observed value
  input wire logic FLAGS_LD, // Load flag register
  input wire logic [bls_pkg::FLW-1:0] FLAGS_IN, // Flag value
  output logic [bls_pkg::FLW-1:0] FLAGS_OUT // Flag register
);
  import bls_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  bls_rf_if rf ();

  bls_regfile u_rf (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .rf (rf.rf)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // zero-extend over stated width
  function automatic logic [DW-1:0] imm_zext(input logic [EXT_W-1:0] ext,
                                             input logic [DW-1:0] imm);
    logic [DW-1:0] v;
    v = imm;
    case (ext)
      EX_BASIC: v = {{(DW-IMM_BASIC_W){1'b0}}, imm[IMM_BASIC_W-1:0]};
      EX_20: v = {{(DW-IMM_20_W){1'b0}}, imm[IMM_20_W-1:0]};
      default: v = imm;
    endcase
    return v;
  endfunction : imm_zext

  // extended forms refused in a delay slot
  function automatic logic ins_legal(input logic [OP_W-1:0] op,
                                     input logic [MODE_W-1:0] md,
                                     input logic [EXT_W-1:0] ext,
                                     input logic dly);
    logic ok;
    ok = 1'b1;
    if (op > OP_MV_UB || md > MD_ABS || ext > EX_24) begin
      ok = 1'b0;
    end
    if (ext != EX_BASIC && (dly || md < MD_SPD || op >= OP_MV_SB)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : ins_legal

  // sign copy into 15..8, 23..16 clear
  function automatic logic [DW-1:0] byte_ext(input logic sgn, input logic [BW-1:0] b);
    return {8'h00, {BW{sgn & b[BW-1]}}, b};
  endfunction : byte_ext

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  bls_state_type state_r, state_nxt;
  logic [OP_W-1:0] op_r, op_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [RIDX_W-1:0] rd_r, rd_nxt;
  logic [RIDX_W-1:0] rb_r, rb_nxt;
  logic [DW-1:0] imm_r, imm_nxt;
  logic req_r, req_nxt;
  logic we_r, we_nxt;
  logic [DW-1:0] addr_r, addr_nxt;
  logic [BW-1:0] wdata_r, wdata_nxt;
  logic done_r, done_nxt;
  logic ill_r, ill_nxt;
  logic [FLW-1:0] flags_r, flags_nxt;
  logic take;
  logic is_load, is_signed, is_move;
  logic [DW-1:0] ea;

  assign INS_READY = (state_r == ST_IDLE) && !RF_LD;
  assign take = INS_VALID && INS_READY;
  assign is_load = (op_r == OP_LD_SB) || (op_r == OP_LOAD_UNSIGNED_BYTE);
  assign is_signed = (op_r == OP_LD_SB) || (op_r == OP_MV_SB);
  assign is_move = (op_r == OP_MV_SB) || (op_r == OP_MV_UB);

  // Effective address from base, stack pointer or immediate
  always_comb begin
    case (mode_r)
      MD_PRED: ea = rf.rd_a - STEP_ONE;
      MD_SPD: ea = SP_VALUE + imm_r;
      MD_ABS: ea = imm_r;
      default: ea = rf.rd_a;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    mode_nxt = mode_r;
    rd_nxt = rd_r;
    rb_nxt = rb_r;
    imm_nxt = imm_r;
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    ill_nxt = 1'b0;
    flags_nxt = flags_r;
    rf.ra_a = INS_RB;
    rf.ra_b = INS_RS;
    rf.ra_c = DBG_SEL;
    rf.we_a = 1'b0;
    rf.wa_a = rd_r;
    rf.wd_a = RST_REG;
    rf.we_b = 1'b0;
    rf.wa_b = rb_r;
    rf.wd_b = RST_REG;
    // flags only change by explicit load
    if (FLAGS_LD && state_r == ST_IDLE) begin
      flags_nxt = FLAGS_IN;
    end
    case (state_r)
      ST_IDLE: begin
        if (RF_LD) begin
          rf.we_b = 1'b1;
          rf.wa_b = RF_LD_SEL;
          rf.wd_b = RF_LD_DATA;
        end else if (take) begin
          if (ins_legal(INS_OP, INS_MODE, INS_EXT, INS_DELAY)) begin
            op_nxt = INS_OP;
            mode_nxt = INS_MODE;
            rd_nxt = INS_RD;
            rb_nxt = INS_RB;
            imm_nxt = imm_zext(INS_EXT, INS_IMM);
            state_nxt = ST_FETCH;
          end else begin
            ill_nxt = 1'b1;
          end
        end
      end
      ST_FETCH: begin
        if (is_move) begin
          rf.we_a = 1'b1;
          rf.wd_a = byte_ext(is_signed, rf.rd_b[BW-1:0]);
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          req_nxt = 1'b1;
          we_nxt = !is_load;
          addr_nxt = ea;
          // store low byte of source only
          wdata_nxt = rf.rd_b[BW-1:0];
          state_nxt = ST_MEM;
        end
      end
      ST_MEM: begin
        if (MEM_ACK) begin
          req_nxt = 1'b0;
          we_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
          rf.we_a = is_load;
          rf.wd_a = byte_ext(is_signed, MEM_RDATA);
          rf.we_b = (mode_r == MD_PINC) || (mode_r == MD_PDEC) || (mode_r == MD_PRED);
          case (mode_r)
            MD_PINC: rf.wd_b = addr_r + STEP_ONE;
            MD_PDEC: rf.wd_b = addr_r - STEP_ONE;
            default: rf.wd_b = addr_r;
          endcase
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= ST_IDLE;
      op_r <= OP_LD_SB;
      mode_r <= MD_IND;
      rd_r <= '0;
      rb_r <= '0;
      imm_r <= RST_REG;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= RST_REG;
      wdata_r <= 8'h00;
      done_r <= 1'b0;
      ill_r <= 1'b0;
      flags_r <= RST_FLAGS;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      mode_r <= mode_nxt;
      rd_r <= rd_nxt;
      rb_r <= rb_nxt;
      imm_r <= imm_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
      ill_r <= ill_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign MEM_REQ = req_r;
  assign MEM_WE = we_r;
  assign MEM_ADDR = addr_r;
  assign MEM_WDATA = wdata_r;
  assign MEM_SIZE = SZ_BYTE;
  assign INS_DONE = done_r;
  assign INS_ILLEGAL = ill_r;
  assign DBG_DATA = rf.rd_c;
  assign FLAGS_OUT = flags_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  a_delay_ext_refused: assert property (
    take && INS_DELAY && INS_EXT != EX_BASIC |=> INS_ILLEGAL && state_r == ST_IDLE)
    else $error("Extended form in delay slot not refused");
  a_post_inc_step: assert property (
    state_r == ST_MEM && MEM_ACK && mode_r == MD_PINC |-> rf.we_b && rf.wd_b == MEM_ADDR + STEP_ONE)
    else $error("Post-increment base update wrong");
  a_post_dec_step: assert property (
    state_r == ST_MEM && MEM_ACK && mode_r == MD_PDEC |-> rf.we_b && rf.wd_b == MEM_ADDR - STEP_ONE)
    else $error("Post-decrement base update wrong");
  a_pre_dec_addr: assert property (
    state_r == ST_FETCH && mode_r == MD_PRED && !is_move |=> MEM_REQ && MEM_ADDR == $past(rf.rd_a) - STEP_ONE)
    else $error("Pre-decrement address wrong");
  a_signed_load: assert property (
    state_r == ST_MEM && MEM_ACK && op_r == OP_LD_SB
    |-> rf.we_a && rf.wd_a == {8'h00, {8{MEM_RDATA[7]}}, MEM_RDATA})
    else $error("Signed byte extension wrong");
  a_unsigned_load: assert property (
    state_r == ST_MEM && MEM_ACK && op_r == OP_LOAD_UNSIGNED_BYTE |-> rf.we_a && rf.wd_a == {16'h0000, MEM_RDATA})
    else $error("Unsigned byte extension wrong");
  a_sp_disp_addr: assert property (
    state_r == ST_FETCH && mode_r == MD_SPD && !is_move |=> MEM_ADDR == $past(SP_VALUE) + imm_r)
    else $error("Stack displacement address wrong");
  a_store_low_byte: assert property (
    state_r == ST_FETCH && op_r == OP_ST_B |=> MEM_WE && MEM_WDATA == $past(rf.rd_b[7:0]))
    else $error("Store byte not source low byte");
  a_flags_held: assert property (
    state_r != ST_IDLE |=> $stable(FLAGS_OUT))
    else $error("Flags changed by byte transfer");
  a_req_held_ack: assert property (
    MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && MEM_SIZE == SZ_BYTE)
    else $error("Request dropped before acknowledge");
endmodule : bls_exec
`default_nettype wire

//--- verilog/bls_regfile.sv
// Eight 24-bit general registers, registered reads, two write ports
`timescale 1ns/100ps
`default_nettype none
module bls_regfile (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  bls_rf_if.rf rf // Access bundle
);
  import bls_pkg::*;
  logic [DW-1:0] regs_r [NREG];
  logic [DW-1:0] regs_nxt [NREG];
  logic [DW-1:0] rda_r, rdb_r, rdc_r;

  // Port A wins when both ports hit one register
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      regs_nxt[i] = regs_r[i];
      if (rf.we_b && rf.wa_b == RIDX_W'(i)) begin
        regs_nxt[i] = rf.wd_b;
      end
      if (rf.we_a && rf.wa_a == RIDX_W'(i)) begin
        regs_nxt[i] = rf.wd_a;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_r[i] <= RST_REG;
      end
      rda_r <= RST_REG;
      rdb_r <= RST_REG;
      rdc_r <= RST_REG;
    end else begin
      regs_r <= regs_nxt;
      rda_r <= regs_r[rf.ra_a];
      rdb_r <= regs_r[rf.ra_b];
      rdc_r <= regs_r[rf.ra_c];
    end
  end

  assign rf.rd_a = rda_r;
  assign rf.rd_b = rdb_r;
  assign rf.rd_c = rdc_r;
endmodule : bls_regfile
`default_nettype wire
